// file: verilog/mqec_cfg.svh
`ifndef MQEC_CFG_SVH
`define MQEC_CFG_SVH
// Register byte offsets
`define MQEC_OFS_CTL0 8'h00
`define MQEC_OFS_CNT0 8'h10
`define MQEC_OFS_STAT 8'h20
`define MQEC_OFS_OVF 8'h24
// Control word fields
`define MQEC_CTL_EV_LSB 0
`define MQEC_CTL_UM_LSB 8
`define MQEC_CTL_RST_BIT 17
`define MQEC_CTL_EN_BIT 22
// Status word fields
`define MQEC_ST_OCC1_LSB 8
`define MQEC_ST_FULL_LSB 16
`define MQEC_ST_NE_LSB 18
// Reset values
`define MQEC_CTL_RESET 17'h00000
`define MQEC_WORD_ZERO 32'h0000_0000
// Queue and counter sizes
`define MQEC_RDQ_DEPTH 22
`define MQEC_NUM_CNT 4
`define MQEC_CNT_WIDTH 32
// Event codes
`define MQEC_EV_ALLOC 8'h10
`define MQEC_EV_NE 8'h11
`define MQEC_EV_FULL0 8'h12
`define MQEC_EV_FULL1 8'h15
`define MQEC_EV_OCC0 8'h80
`define MQEC_EV_OCC1 8'h81
`define MQEC_EV_ACC 8'hD2
`define MQEC_EV_REJ 8'hD4
`define MQEC_EV_STRV 8'hD7
`define MQEC_EV_CANARY 8'hD9
`endif

// file: verilog/mqec_pkg.sv
package mqec_pkg;
	// Queue occupancy, wide enough for the deepest queue
	typedef logic [4:0] mqec_occ_t;
	typedef logic [31:0] mqec_word_t;
	// Per-counter control: enable, unit mask, event code
	typedef struct packed {
		logic en;
		logic [7:0] umask;
		logic [7:0] ev;
	} mqec_ctl_t;
endpackage: mqec_pkg

// file: verilog/mqec_q_if.sv
`timescale 1ns/1ps
// Read pending queue status from one tracker to the event logic
interface mqec_q_if;
	import mqec_pkg::*;
	mqec_occ_t occ;
	logic full;
	logic ne;
	logic alloc;
	modport src(output occ, output full, output ne, output alloc);
	modport snk(input occ, input full, input ne, input alloc);
endinterface: mqec_q_if

// file: verilog/mqec_rdq.sv
`timescale 1ns/1ps
`include "mqec_cfg.svh"
// Occupancy tracker of one pseudo-channel read pending queue
module mqec_rdq #(
	parameter int DEPTH = `MQEC_RDQ_DEPTH
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic req,
	input wire logic req_isochronous_class,
	input wire logic cas,
	input wire logic cas_isochronous_class,
	mqec_q_if.src q
);
	import mqec_pkg::*;
	localparam mqec_occ_t DMAX = mqec_occ_t'(DEPTH);
	logic alloc_r;
	logic iso_r;
	mqec_occ_t occ_r;
	mqec_occ_t occ_nxt;
	mqec_occ_t niso_r;
	mqec_occ_t niso_nxt;
	logic full_r;
	logic ne_r;

	// Entry is taken the cycle after the request enters
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			alloc_r <= 1'b0;
			iso_r <= 1'b0;
		end
		else
		begin
			alloc_r <= req;
			iso_r <= req_isochronous_class;
		end
	end

	// Next occupancy: all entries, and non-isochronous ones alone
	always_comb
	begin
		occ_nxt = occ_r;
		niso_nxt = niso_r;
		if (alloc_r && !cas && occ_r != DMAX)
			occ_nxt = occ_r + 5'h01;
		else if (cas && !alloc_r && occ_r != 5'h00)
			occ_nxt = occ_r - 5'h01;
		if (alloc_r && !iso_r && !(cas && !cas_isochronous_class) && niso_r != DMAX)
			niso_nxt = niso_r + 5'h01;
		else if (cas && !cas_isochronous_class && !(alloc_r && !iso_r) && niso_r != 5'h00)
			niso_nxt = niso_r - 5'h01;
	end

	// Occupancy and derived full and not-empty flags
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			occ_r <= 5'h00;
			niso_r <= 5'h00;
			full_r <= 1'b0;
			ne_r <= 1'b0;
		end
		else
		begin
			occ_r <= occ_nxt;
			niso_r <= niso_nxt;
			full_r <= (niso_nxt == DMAX);
			ne_r <= (occ_nxt != 5'h00);
		end
	end

	// Status toward the event logic
	assign q.occ = occ_r;
	assign q.full = full_r;
	assign q.ne = ne_r;
	assign q.alloc = alloc_r;

	default clocking @(posedge clk);
	endclocking
	default disable iff (!nrst);

	a_full_by_niso: assert property ($rose(full_r) |-> $past(alloc_r && !iso_r))
		else $error("queue became full without a non-isochronous allocation");
	a_alloc_takes: assert property ((req && !cas) ##1 (!cas && occ_r != DMAX)
		|=> occ_r == $past(occ_r) + 5'h01)
		else $error("allocation did not take an entry");
	a_cas_frees: assert property ((cas && !alloc_r && occ_r != 5'h00)
		|=> occ_r == $past(occ_r) - 5'h01)
		else $error("column access did not release an entry");
endmodule: mqec_rdq

// file: verilog/mqec_cnt.sv
`timescale 1ns/1ps
`include "mqec_cfg.svh"
// One general counter with its control word and overflow flag
module mqec_cnt #(
	parameter int CW = `MQEC_CNT_WIDTH
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ctl_wr,
	input wire logic cnt_wr,
	input wire mqec_pkg::mqec_word_t wdata,
	input wire mqec_pkg::mqec_occ_t inc,
	output mqec_pkg::mqec_ctl_t ctl_r,
	output logic [CW-1:0] cnt_r,
	output logic ovf_r
);
	import mqec_pkg::*;
	logic [CW:0] sum;

	// Add the increment with carry out
	assign sum = {1'b0, cnt_r} + {{(CW-4){1'b0}}, inc};

	// Control word written by software
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			ctl_r <= `MQEC_CTL_RESET;
		else if (ctl_wr)
			ctl_r <= {wdata[`MQEC_CTL_EN_BIT], wdata[15:0]};
	end

	// Count; a write loads, the reset bit clears
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			cnt_r <= '0;
		else if (cnt_wr)
			cnt_r <= wdata[CW-1:0];
		else if (ctl_wr && wdata[`MQEC_CTL_RST_BIT])
			cnt_r <= '0;
		else
			cnt_r <= sum[CW-1:0];
	end

	// Sticky overflow, the clearing write wins over a wrap
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			ovf_r <= 1'b0;
		else if (sum[CW] && !cnt_wr)
			ovf_r <= 1'b1;
		else if (cnt_wr)
			ovf_r <= 1'b0;
	end
endmodule: mqec_cnt

// file: verilog/mqec_top.sv
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "mqec_cfg.svh"
module mqec_top #(
	parameter int NCNT = `MQEC_NUM_CNT,
	parameter int CW = `MQEC_CNT_WIDTH,
	parameter int DEPTH = `MQEC_RDQ_DEPTH
) (
	input wire logic MCLK,
	input wire logic NRST,
	input wire logic [7:0] ADDR,
	input wire mqec_pkg::mqec_word_t WDATA,
	input wire logic WR,
	input wire logic RD,
	output mqec_pkg::mqec_word_t RDATA,
	input wire logic [1:0] RDQ_REQ,
	input wire logic [1:0] RDQ_REQ_ISOCHRONOUS_CLASS,
	input wire logic [1:0] RDQ_CAS,
	input wire logic [1:0] RDQ_CAS_ISOCHRONOUS_CLASS,
	output logic [1:0] RDQ_FULL,
	input wire logic [7:0] SB_ACCESS,
	input wire logic [7:0] SCOREBOARD_CANARY_EVENT,
	input wire logic [4:0] SCOREBOARD_REJECT_EVENT,
	input wire logic [4:0] SB_STARVE
);
	import mqec_pkg::*;

	mqec_ctl_t ctl [NCNT];
	logic [CW-1:0] cnt [NCNT];
	logic ovf [NCNT];
	mqec_occ_t inc [NCNT];
	logic ctl_wr [NCNT];
	logic cnt_wr [NCNT];
	mqec_word_t rdata_r;
	mqec_word_t rdata_nxt;
	logic [1:0] full_r;

	mqec_q_if q0();
	mqec_q_if q1();

	// Queue trackers, one per pseudo-channel
	mqec_rdq #(
		.DEPTH(DEPTH)
	) u_rdq0 (
		.clk(MCLK),
		.nrst(NRST),
		.req(RDQ_REQ[0]),
		.req_isochronous_class(RDQ_REQ_ISOCHRONOUS_CLASS[0]),
		.cas(RDQ_CAS[0]),
		.cas_isochronous_class(RDQ_CAS_ISOCHRONOUS_CLASS[0]),
		.q(q0)
	);

	mqec_rdq #(
		.DEPTH(DEPTH)
	) u_rdq1 (
		.clk(MCLK),
		.nrst(NRST),
		.req(RDQ_REQ[1]),
		.req_isochronous_class(RDQ_REQ_ISOCHRONOUS_CLASS[1]),
		.cas(RDQ_CAS[1]),
		.cas_isochronous_class(RDQ_CAS_ISOCHRONOUS_CLASS[1]),
		.q(q1)
	);

	// Full flags toward the home agent, which stops sending reads
	always_ff @(posedge MCLK or negedge NRST)
	begin
		if (!NRST)
			full_r <= 2'h0;
		else
			full_r <= {q1.full, q0.full};
	end

	assign RDQ_FULL = full_r;

	// All checks below run on the controller clock and sleep during reset
	default clocking @(posedge MCLK);
	endclocking
	default disable iff (!NRST);

	// General counters 0 to 3, the only ones that take these events
	for (genvar i = 0; i < NCNT; i++)
	begin: g_cnt
		// Bus write decode for this counter
		assign ctl_wr[i] = WR && (ADDR == 8'(`MQEC_OFS_CTL0 + 4 * i));
		assign cnt_wr[i] = WR && (ADDR == 8'(`MQEC_OFS_CNT0 + 4 * i));

		// Event selection and per-cycle increment
		always_comb
		begin
			inc[i] = 5'h00;
			if (ctl[i].en)
			begin
				case (ctl[i].ev)
					`MQEC_EV_FULL0:
						inc[i] = {4'h0, q0.full};
					`MQEC_EV_FULL1:
						inc[i] = {4'h0, q1.full};
					`MQEC_EV_NE:
						inc[i] = {4'h0, (ctl[i].umask[0] && q0.ne)
							|| (ctl[i].umask[1] && q1.ne)};
					`MQEC_EV_ALLOC:
						inc[i] = {4'h0, (ctl[i].umask[0] && q0.alloc)
							|| (ctl[i].umask[1] && q1.alloc)};
					`MQEC_EV_OCC0:
						inc[i] = q0.occ;
					`MQEC_EV_OCC1:
						inc[i] = q1.occ;
					`MQEC_EV_ACC:
						inc[i] = {4'h0, |(ctl[i].umask & SB_ACCESS)};
					`MQEC_EV_CANARY:
						inc[i] = {4'h0, |(ctl[i].umask & SCOREBOARD_CANARY_EVENT)};
					`MQEC_EV_REJ:
						inc[i] = {4'h0, |(ctl[i].umask[4:0] & SCOREBOARD_REJECT_EVENT)};
					`MQEC_EV_STRV:
						inc[i] = {4'h0, |(ctl[i].umask[4:0] & SB_STARVE)};
					default:
						inc[i] = 5'h00;
				endcase
			end
		end

		mqec_cnt #(
			.CW(CW)
		) u_cnt (
			.clk(MCLK),
			.nrst(NRST),
			.ctl_wr(ctl_wr[i]),
			.cnt_wr(cnt_wr[i]),
			.wdata(WDATA),
			.inc(inc[i]),
			.ctl_r(ctl[i]),
			.cnt_r(cnt[i]),
			.ovf_r(ovf[i])
		);

		// Per-counter checks of the event selection, live on every counter
		a_full_cycle_count: assert property (
			(!WR && ctl[i].en && ctl[i].ev == `MQEC_EV_FULL0 && q0.full)
			|=> cnt[i] == $past(cnt[i]) + 1'b1)
			else $error("full cycle not counted");
		a_full1_cycle_count: assert property (
			(!WR && ctl[i].en && ctl[i].ev == `MQEC_EV_FULL1 && q1.full)
			|=> cnt[i] == $past(cnt[i]) + 1'b1)
			else $error("channel 1 full cycle not counted");
		a_ne_mask_off: assert property (
			(!WR && ctl[i].en && ctl[i].ev == `MQEC_EV_NE
			&& ctl[i].umask[1:0] == 2'h1 && !q0.ne)
			|=> $stable(cnt[i]))
			else $error("empty channel 0 counted as not empty");
		a_alloc_ch1_count: assert property (
			(!WR && ctl[i].en && ctl[i].ev == `MQEC_EV_ALLOC
			&& ctl[i].umask[1] && q1.alloc)
			|=> cnt[i] == $past(cnt[i]) + 1'b1)
			else $error("channel 1 allocation not counted");
		a_occ_accumulate: assert property (
			(!WR && ctl[i].en && ctl[i].ev == `MQEC_EV_OCC1)
			|=> cnt[i] == $past(cnt[i]) + $past(q1.occ))
			else $error("occupancy not accumulated");
		a_occ0_accumulate: assert property (
			(!WR && ctl[i].en && ctl[i].ev == `MQEC_EV_OCC0)
			|=> cnt[i] == $past(cnt[i]) + $past(q0.occ))
			else $error("channel 0 occupancy not accumulated");
		a_access_masked: assert property (
			(!WR && ctl[i].en && ctl[i].ev == `MQEC_EV_ACC
			&& (ctl[i].umask & SB_ACCESS) == 8'h00)
			|=> $stable(cnt[i]))
			else $error("unselected access counted");
		a_canary_count: assert property (
			(!WR && ctl[i].en && ctl[i].ev == `MQEC_EV_CANARY
			&& |(ctl[i].umask & SCOREBOARD_CANARY_EVENT))
			|=> cnt[i] == $past(cnt[i]) + 1'b1)
			else $error("selected canary event not counted");
		a_reject_count: assert property (
			(!WR && ctl[i].en && ctl[i].ev == `MQEC_EV_REJ
			&& |(ctl[i].umask[4:0] & SCOREBOARD_REJECT_EVENT))
			|=> cnt[i] == $past(cnt[i]) + 1'b1)
			else $error("selected reject not counted");
		a_starve_count: assert property (
			(!WR && ctl[i].en && ctl[i].ev == `MQEC_EV_STRV
			&& |(ctl[i].umask[4:0] & SB_STARVE))
			|=> cnt[i] == $past(cnt[i]) + 1'b1)
			else $error("starvation allocation not counted");
		a_code_unused: assert property (
			(!WR && ctl[i].en && !(ctl[i].ev inside {`MQEC_EV_ALLOC, `MQEC_EV_NE,
			`MQEC_EV_FULL0, `MQEC_EV_FULL1, `MQEC_EV_OCC0, `MQEC_EV_OCC1,
			`MQEC_EV_ACC, `MQEC_EV_REJ, `MQEC_EV_STRV, `MQEC_EV_CANARY}))
			|=> $stable(cnt[i]))
			else $error("unused event code counted");
	end

	// Read mux: controls, counts, queue status, overflow flags
	always_comb
	begin
		rdata_nxt = `MQEC_WORD_ZERO;
		for (int k = 0; k < NCNT; k++)
		begin
			if (ADDR == 8'(`MQEC_OFS_CTL0 + 4 * k))
				rdata_nxt = {9'h000, ctl[k].en, 6'h00, ctl[k].umask, ctl[k].ev};
			if (ADDR == 8'(`MQEC_OFS_CNT0 + 4 * k))
				rdata_nxt = 32'(cnt[k]);
			if (ADDR == `MQEC_OFS_OVF)
				rdata_nxt[k] = ovf[k];
		end
		if (ADDR == `MQEC_OFS_STAT)
		begin
			rdata_nxt[4:0] = q0.occ;
			rdata_nxt[`MQEC_ST_OCC1_LSB +: 5] = q1.occ;
			rdata_nxt[`MQEC_ST_FULL_LSB +: 2] = {q1.full, q0.full};
			rdata_nxt[`MQEC_ST_NE_LSB +: 2] = {q1.ne, q0.ne};
		end
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge MCLK or negedge NRST)
	begin
		if (!NRST)
			rdata_r <= `MQEC_WORD_ZERO;
		else if (RD)
			rdata_r <= rdata_nxt;
		else
			rdata_r <= `MQEC_WORD_ZERO;
	end

	assign RDATA = rdata_r;

	// Read data fall back to zero when no read was taken
	a_rdata_idle: assert property (!RD |=> RDATA == `MQEC_WORD_ZERO)
		else $error("read data outside the read cycle");
	a_idle_hold: assert property (
		(!WR && !ctl[1].en)[*2] |-> $stable(cnt[1]))
		else $error("disabled counter moved");
endmodule: mqec_top

// file: tb/mqec_ha_model.sv
`timescale 1ns/1ps
// Home agent stand-in that sends credited reads into both pseudo-channels
module mqec_ha_model #(
	parameter int DEPTH = 22
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [1:0] go,
	input wire logic [1:0] isochronous_class,
	input wire logic [1:0] cas,
	input wire logic [1:0] full,
	output logic [1:0] req,
	output logic [1:0] req_isochronous_class
);
	int cred [2];
	logic [1:0] send;
	// A read goes out only with a credit in hand and never into a full queue
	always_comb
	begin
		for (int c = 0; c < 2; c++)
			send[c] = go[c] && cred[c] > 0 && !full[c];
	end
	// Credits are spent per request and come back with each column access
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cred <= '{DEPTH, DEPTH};
			req <= 2'h0;
			req_isochronous_class <= 2'h0;
		end
		else
		begin
			for (int c = 0; c < 2; c++)
			begin
				req[c] <= send[c];
				req_isochronous_class[c] <= send[c] ? isochronous_class[c] : ~req_isochronous_class[c]; // Class toggles when idle
				cred[c] <= cred[c] - int'(send[c]) + int'(cas[c]);
			end
		end
	end
endmodule: mqec_ha_model

// file: tb/mqec_top_tb.sv
`timescale 1ns/1ps
`include "mqec_cfg.svh"
module mqec_top_tb;
	import mqec_pkg::*;
	typedef struct {mqec_word_t v; int k; int i;} mqec_exp_t;
	logic MCLK, NRST, WR, RD;
	logic [7:0] ADDR;
	mqec_word_t WDATA, RDATA;
	logic [1:0] RDQ_REQ, RDQ_REQ_ISOCHRONOUS_CLASS, RDQ_CAS, RDQ_CAS_ISOCHRONOUS_CLASS, RDQ_FULL, go, isochronous_class;
	logic [7:0] SB_ACCESS, SCOREBOARD_CANARY_EVENT;
	logic [4:0] SCOREBOARD_REJECT_EVENT, SB_STARVE;
	logic rd_d = 1'b0;
	logic [25:0] r;
	logic [7:0] um [4];
	logic [7:0] evk [4];
	logic [7:0] ra [5] = '{8'h00, 8'h10, 8'h20, 8'h24, 8'hFC};
	logic [7:0] sc [4] = '{`MQEC_EV_ACC, `MQEC_EV_CANARY, `MQEC_EV_REJ, `MQEC_EV_STRV};
	mqec_word_t base [4];
	mqec_word_t sum [4];
	mqec_exp_t e;
	mqec_exp_t expq [$];
	int mismatches = 0;
	int checked = 0;
	mqec_top uut (.MCLK, .NRST, .ADDR, .WDATA, .WR, .RD, .RDATA, .RDQ_REQ, .RDQ_REQ_ISOCHRONOUS_CLASS,
		.RDQ_CAS, .RDQ_CAS_ISOCHRONOUS_CLASS, .RDQ_FULL, .SB_ACCESS, .SCOREBOARD_CANARY_EVENT, .SCOREBOARD_REJECT_EVENT, .SB_STARVE);
	mqec_ha_model #(.DEPTH(`MQEC_RDQ_DEPTH)) ha (.clk(MCLK), .nrst(NRST), .go(go), .isochronous_class(isochronous_class),
		.cas(RDQ_CAS), .full(RDQ_FULL), .req(RDQ_REQ), .req_isochronous_class(RDQ_REQ_ISOCHRONOUS_CLASS));
	// Free-running controller clock
	initial
	begin
		MCLK = 1'b0;
		forever #20 MCLK = ~MCLK;
	end
	function void chk(input mqec_word_t got, input mqec_word_t exp);
		checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endfunction: chk
	// Control word with enable and count clear set
	function mqec_word_t ctl(input logic [7:0] ev, input logic [7:0] m);
		return 32'h0042_0000 | {16'h0000, m, ev};
	endfunction: ctl
	task wr(input logic [7:0] a, input mqec_word_t d);
		WR <= 1'b1;
		ADDR <= a;
		WDATA <= d;
		@(posedge MCLK);
		WR <= 1'b0;
		@(posedge MCLK);
	endtask: wr
	// Kind 0 compares, 1 captures a base, 2 compares the rise since the base
	task rd(input logic [7:0] a, input mqec_word_t v, input int k, input int i);
		expq.push_back('{v, k, i});
		RD <= 1'b1;
		ADDR <= a;
		@(posedge MCLK);
		RD <= 1'b0;
		@(posedge MCLK);
	endtask: rd
	// Two counter reads ten edges apart
	task dpair(input int k, input mqec_word_t d);
		rd(8'h10 + 8'(4 * k), 32'h0, 1, k);
		repeat (8) @(posedge MCLK);
		rd(8'h10 + 8'(4 * k), d, 2, k);
	endtask: dpair
	task conclude;
		$display("counts: checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask: conclude
	// Read data stands in the cycle after the strobe; take the oldest note then
	always @(posedge MCLK)
	begin
		rd_d <= RD;
		if (rd_d === 1'b1)
		begin
			e = expq.pop_front();
			if (e.k == 1)
				base[e.i] = RDATA;
			else
				chk(e.k == 2 ? RDATA - base[e.i] : RDATA, e.v);
		end
	end
	// Hang guard
	initial
	begin
		#200000;
		mismatches++;
		conclude();
	end
	initial
	begin
		NRST = 1'b0;
		{WR, RD, ADDR, WDATA, RDQ_CAS, RDQ_CAS_ISOCHRONOUS_CLASS, go, isochronous_class} = '0;
		{SB_ACCESS, SCOREBOARD_CANARY_EVENT, SCOREBOARD_REJECT_EVENT, SB_STARVE} = '0;
		void'($urandom(32'h72f16757));
		repeat (5) @(posedge MCLK);
		NRST <= 1'b1;
		@(posedge MCLK);
		foreach (ra[j]) rd(ra[j], 32'h0, 0, 0);
		$display("test reset done");
		wr(8'h00, ctl(`MQEC_EV_ALLOC, 8'h01));
		wr(8'h04, ctl(`MQEC_EV_ALLOC, 8'h02));
		wr(8'h08, ctl(`MQEC_EV_NE, 8'h00));
		wr(8'h0C, ctl(8'h42, 8'hFF));
		go <= 2'b11;
		isochronous_class <= 2'b01;
		@(posedge MCLK);
		isochronous_class <= 2'b00;
		repeat (40) @(posedge MCLK);
		rd(8'h20, 32'h000E_1616, 0, 0);
		RDQ_CAS <= 2'b01;
		RDQ_CAS_ISOCHRONOUS_CLASS <= 2'b01;
		@(posedge MCLK);
		RDQ_CAS <= 2'b00;
		RDQ_CAS_ISOCHRONOUS_CLASS <= 2'b00;
		repeat (10) @(posedge MCLK);
		rd(8'h20, 32'h000F_1616, 0, 0);
		chk({30'h0, RDQ_FULL}, 32'h3);
		rd(8'h10, 32'd23, 0, 0);
		rd(8'h14, 32'd22, 0, 0);
		rd(8'h18, 32'h0, 0, 0);
		rd(8'h1C, 32'h0, 0, 0);
		$display("test fill done");
		wr(8'h00, ctl(`MQEC_EV_NE, 8'h01));
		wr(8'h04, ctl(`MQEC_EV_OCC0, 8'h00));
		wr(8'h08, ctl(`MQEC_EV_FULL0, 8'h00));
		wr(8'h0C, ctl(`MQEC_EV_FULL1, 8'h00));
		go <= 2'b00;
		dpair(0, 32'd10);
		dpair(1, 32'd220);
		dpair(2, 32'd10);
		dpair(3, 32'd10);
		RDQ_CAS <= 2'b11;
		repeat (22) @(posedge MCLK);
		RDQ_CAS <= 2'b00;
		repeat (4) @(posedge MCLK);
		rd(8'h20, 32'h0, 0, 0);
		chk({30'h0, RDQ_FULL}, 32'h0);
		$display("test full done");
		repeat (4)
		begin
			foreach (um[k]) um[k] = 8'($urandom);
			foreach (um[k]) wr(8'(4 * k), ctl(sc[k], um[k]));
			foreach (um[k]) rd(8'h10 + 8'(4 * k), 32'h0, 1, k);
			sum = '{32'h0, 32'h0, 32'h0, 32'h0};
			repeat (8)
			begin
				r = 26'($urandom);
				{SB_ACCESS, SCOREBOARD_CANARY_EVENT, SCOREBOARD_REJECT_EVENT, SB_STARVE} <= r;
				evk = '{r[25:18], r[17:10], {3'h0, r[9:5]}, {3'h0, r[4:0]}};
				foreach (sum[k]) sum[k] += 32'(|(um[k] & evk[k]));
				@(posedge MCLK);
			end
			{SB_ACCESS, SCOREBOARD_CANARY_EVENT, SCOREBOARD_REJECT_EVENT, SB_STARVE} <= '0;
			@(posedge MCLK);
			rd(8'h10, sum[0], 2, 0);
			rd(8'h14, sum[1], 2, 1);
			rd(8'h18, sum[2], 2, 2);
			rd(8'h1C, sum[3], 2, 3);
		end
		wr(8'h00, ctl(`MQEC_EV_ACC, 8'h01));
		wr(8'h10, 32'hFFFF_FFFF);
		SB_ACCESS <= 8'h01;
		@(posedge MCLK);
		SB_ACCESS <= 8'h00;
		@(posedge MCLK);
		rd(8'h24, 32'h1, 0, 0);
		rd(8'h10, 32'h0, 0, 0);
		$display("test scoreboard done");
		repeat (3) @(posedge MCLK);
		conclude();
	end
endmodule: mqec_top_tb
